/* File: hdl/demag_pkg.sv */
// shared constants, carriers and state types for the demagnetisation event detector
package demag_pkg;

	// ****************************************
	// clock and timing
	// ****************************************
	localparam int CLK_MHZ            = 200;  // pclk rate
	localparam int WIN_SHORT_STEP_US  = 5;    // codes 0..7: 5 us steps
	localparam int WIN_LONG_BASE_US   = 60;   // code 8 gives 60 us
	localparam int WIN_LONG_STEP_US   = 20;   // codes 8..15: 20 us steps
	localparam int WIN_MAX_US         = 200;  // longest window
	localparam int SAMPLE_BASE_CYC    = 50;   // sampling divider unit, cycles
	localparam int WIN_W              = 16;   // blanking counter width

	// ****************************************
	// register offsets (byte addresses)
	// ****************************************
	localparam logic [7:0] ADDR_PHASE_STATE = 8'h00;
	localparam logic [7:0] ADDR_CONTROL_A   = 8'h04;
	localparam logic [7:0] ADDR_CONTROL_C   = 8'h08;
	localparam logic [7:0] ADDR_PRESCALER   = 8'h0c;
	localparam logic [7:0] ADDR_DEMAG_FILT  = 8'h10;
	localparam logic [7:0] ADDR_PARAM       = 8'h14;
	localparam logic [7:0] ADDR_POLARITY    = 8'h18;
	localparam logic [7:0] ADDR_COMMAND     = 8'h1c;
	localparam logic [7:0] ADDR_STATUS      = 8'h20;

	// ****************************************
	// field positions
	// ****************************************
	localparam int CRA_CKE   = 0;
	localparam int CRA_DAC   = 1;
	localparam int CRA_SR    = 2;
	localparam int POL_CPB   = 0;
	localparam int POL_ZVD   = 1;
	localparam int POL_VMODE = 2;
	localparam int POL_HDM   = 3;
	localparam int CMD_SWC   = 0;
	localparam int DF_LIMIT  = 0;  // demag_event_limit [3:0]
	localparam int DF_WIN    = 4;  // demag_window_len [7:4]
	localparam int ST_DFLAG  = 0;
	localparam int ST_CMP    = 1;
	localparam int ST_STATE  = 2;  // [3:2]
	localparam int ST_COUNT  = 4;  // [7:4]
	localparam int ST_SPEED  = 8;  // [10:8]

	// ****************************************
	// codes and reset values
	// ****************************************
	localparam logic [1:0] IS_A        = 2'h0;
	localparam logic [1:0] IS_B        = 2'h1;
	localparam logic [1:0] IS_C        = 2'h2;
	localparam logic [1:0] TES_POS     = 2'h0;
	localparam logic [2:0] VR_EXT      = 3'h7;
	localparam logic [3:0] WIN_RESET   = 4'hf;
	localparam logic [3:0] LIMIT_RESET = 4'h0;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic [1:0] input_select;
		logic       clk_enable;
		logic       dac_enable;
		logic       sensor_mode_bit;
		logic [2:0] threshold_select;
		logic [3:0] sampling_window_rate;
		logic [3:0] demag_window_len;
		logic [3:0] demag_event_limit;
		logic [1:0] sensor_type_select;
		logic       edge_polarity_bit;
		logic       zero_vs_demag_polarity;
		logic       voltage_mode;
		logic       hw_demag_en;
	} cfg_t;

	typedef struct packed {
		logic c_hw;        // hardware commutation pulse
		logic d_sim;       // simulated demagnetisation pulse
		logic z_evt;       // zero crossing accepted downstream
		logic pwm_sample;  // voltage mode sampling pulse
	} evt_in_t;

	typedef enum logic [1:0] {ST_WAIT_C, ST_BLANK, ST_FILTER, ST_WAIT_Z} det_state_t;

endpackage

/* File: hdl/pin_sync.sv */
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
	parameter int W = 3
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] pin_in,
	output var  logic [W-1:0] pin_q
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] q_r;
	logic [W-1:0] q_nxt;

	// ****************************************
	// agreement filter
	// ****************************************
	// stage one feeds stage two only, never the filter
	always_comb begin
		for (int i = 0; i < W; i++) begin
			q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q_r[i];
		end
	end

	// registers of the chain
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			q_r  <= '0;
		end else begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			q_r  <= q_nxt;
		end
	end

	assign pin_q = q_r;
endmodule
`default_nettype wire

/* File: hdl/demag_detector.sv */
// phase input stage with blanking window and consecutive demagnetisation event filter
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module demag_detector #(
	parameter int CYC_PER_US  = demag_pkg::CLK_MHZ,
	parameter int SAMPLE_BASE = demag_pkg::SAMPLE_BASE_CYC
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic [7:0]          paddr,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [31:0]         pwdata,
	output var  logic [31:0]         prdata,
	output var  logic                pready,
	output var  logic                pslverr,
	input  wire logic                phase_input_a,
	input  wire logic                phase_input_b,
	input  wire logic                phase_input_c,
	input  wire demag_pkg::evt_in_t  evt_in,
	output var  logic                comparator_on,
	output var  logic [2:0]          thr_select,
	output var  logic                ext_threshold_sel,
	output var  logic                d_event,
	output var  logic                z_detect_enable,
	output var  logic                zc_sample,
	output var  logic [2:0]          speed_inputs
);
	// ****************************************
	// elaboration checks
	// ****************************************
	if (CYC_PER_US < 1 || CYC_PER_US * demag_pkg::WIN_MAX_US > 65535) begin : g_bad_rate
		$error("CYC_PER_US out of range");
	end
	if (SAMPLE_BASE < 1 || SAMPLE_BASE > 4096) begin : g_bad_base
		$error("SAMPLE_BASE out of range");
	end

	// ****************************************
	// declarations
	// ****************************************
	demag_pkg::cfg_t       cfg_r, cfg_nxt;
	demag_pkg::det_state_t state_r, state_nxt;
	logic [31:0]           prdata_r, prdata_nxt;
	logic                  pready_r, pready_nxt;
	logic                  pslverr_r, pslverr_nxt;
	logic                  swc_r, swc_nxt;
	logic                  d_flag_r, d_flag_nxt;
	logic [2:0]            phase_q;
	logic [15:0]           div_r, div_nxt;
	logic                  tick;
	logic                  cmp_on_r, cmp_on_nxt;
	logic                  cmp_level;
	logic                  zc_r, zc_nxt;
	logic [demag_pkg::WIN_W-1:0] win_r, win_nxt, win_cycles;
	logic [3:0]            count_r, count_nxt;
	logic                  d_pulse_r, d_pulse_nxt;
	logic                  zen_r, zen_nxt;
	logic [2:0]            speed_r, speed_nxt;
	logic                  ext_r, ext_nxt;
	logic                  det_active, c_evt, d_level, d_match, access, done, mapped;

	// ****************************************
	// pin synchronisation
	// ****************************************
	pin_sync #(.W(3)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.pin_in  ({phase_input_c, phase_input_b, phase_input_a}),
		.pin_q   (phase_q)
	);

	// ****************************************
	// apb slave and registers
	// ****************************************
	// one wait state so read data comes from a flop
	always_comb begin
		access      = psel && penable && !pready_r;
		done        = psel && penable && pready_r;
		mapped      = (paddr <= demag_pkg::ADDR_STATUS) && (paddr[1:0] == 2'h0);
		pready_nxt  = access;
		pslverr_nxt = access && !mapped;
		prdata_nxt  = prdata_r;
		cfg_nxt     = cfg_r;
		swc_nxt     = 1'b0;
		d_flag_nxt  = d_flag_r;
		if (access) begin
			prdata_nxt = 32'h0000_0000;
			case (paddr)
				demag_pkg::ADDR_PHASE_STATE: prdata_nxt[1:0] = cfg_r.input_select;
				demag_pkg::ADDR_CONTROL_A: begin
					prdata_nxt[demag_pkg::CRA_CKE] = cfg_r.clk_enable;
					prdata_nxt[demag_pkg::CRA_DAC] = cfg_r.dac_enable;
					prdata_nxt[demag_pkg::CRA_SR]  = cfg_r.sensor_mode_bit;
				end
				demag_pkg::ADDR_CONTROL_C: prdata_nxt[2:0] = cfg_r.threshold_select;
				demag_pkg::ADDR_PRESCALER: prdata_nxt[3:0] = cfg_r.sampling_window_rate;
				demag_pkg::ADDR_DEMAG_FILT: begin
					prdata_nxt[demag_pkg::DF_LIMIT +: 4] = cfg_r.demag_event_limit;
					prdata_nxt[demag_pkg::DF_WIN +: 4]   = cfg_r.demag_window_len;
				end
				demag_pkg::ADDR_PARAM: prdata_nxt[1:0] = cfg_r.sensor_type_select;
				demag_pkg::ADDR_POLARITY: begin
					prdata_nxt[demag_pkg::POL_CPB]   = cfg_r.edge_polarity_bit;
					prdata_nxt[demag_pkg::POL_ZVD]   = cfg_r.zero_vs_demag_polarity;
					prdata_nxt[demag_pkg::POL_VMODE] = cfg_r.voltage_mode;
					prdata_nxt[demag_pkg::POL_HDM]   = cfg_r.hw_demag_en;
				end
				demag_pkg::ADDR_STATUS: begin
					prdata_nxt[demag_pkg::ST_DFLAG]     = d_flag_r;
					prdata_nxt[demag_pkg::ST_CMP]       = cmp_level;
					prdata_nxt[demag_pkg::ST_STATE +: 2] = state_r;
					prdata_nxt[demag_pkg::ST_COUNT +: 4] = count_r;
					prdata_nxt[demag_pkg::ST_SPEED +: 3] = speed_r;
				end
				default: prdata_nxt = 32'h0000_0000;
			endcase
		end
		if (done && pwrite) begin
			case (paddr)
				demag_pkg::ADDR_PHASE_STATE: cfg_nxt.input_select = pwdata[1:0];
				demag_pkg::ADDR_CONTROL_A: begin
					cfg_nxt.clk_enable      = pwdata[demag_pkg::CRA_CKE];
					cfg_nxt.dac_enable      = pwdata[demag_pkg::CRA_DAC];
					cfg_nxt.sensor_mode_bit = pwdata[demag_pkg::CRA_SR];
				end
				demag_pkg::ADDR_CONTROL_C: cfg_nxt.threshold_select = pwdata[2:0];
				demag_pkg::ADDR_PRESCALER: cfg_nxt.sampling_window_rate = pwdata[3:0];
				demag_pkg::ADDR_DEMAG_FILT: begin
					cfg_nxt.demag_event_limit = pwdata[demag_pkg::DF_LIMIT +: 4];
					cfg_nxt.demag_window_len  = pwdata[demag_pkg::DF_WIN +: 4];
				end
				demag_pkg::ADDR_PARAM: cfg_nxt.sensor_type_select = pwdata[1:0];
				demag_pkg::ADDR_POLARITY: begin
					cfg_nxt.edge_polarity_bit      = pwdata[demag_pkg::POL_CPB];
					cfg_nxt.zero_vs_demag_polarity = pwdata[demag_pkg::POL_ZVD];
					cfg_nxt.voltage_mode           = pwdata[demag_pkg::POL_VMODE];
					cfg_nxt.hw_demag_en            = pwdata[demag_pkg::POL_HDM];
				end
				demag_pkg::ADDR_COMMAND: swc_nxt = pwdata[demag_pkg::CMD_SWC];
				demag_pkg::ADDR_STATUS: if (pwdata[demag_pkg::ST_DFLAG]) d_flag_nxt = 1'b0;
				default: swc_nxt = 1'b0;
			endcase
		end
		if (d_pulse_nxt) d_flag_nxt = 1'b1; // set beats clear
	end

	// register file flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_r                   <= '0;
			cfg_r.demag_window_len  <= demag_pkg::WIN_RESET;
			cfg_r.demag_event_limit <= demag_pkg::LIMIT_RESET;
			cfg_r.hw_demag_en       <= 1'b1;
			prdata_r                <= 32'h0000_0000;
			pready_r                <= 1'b0;
			pslverr_r               <= 1'b0;
			swc_r                   <= 1'b0;
			d_flag_r                <= 1'b0;
		end else begin
			cfg_r     <= cfg_nxt;
			prdata_r  <= prdata_nxt;
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			swc_r     <= swc_nxt;
			d_flag_r  <= d_flag_nxt;
		end
	end

	// ****************************************
	// input stage and sampling
	// ****************************************
	// comparator modelled by the synchronised level of the routed phase
	always_comb begin
		cmp_on_nxt = (cfg_nxt.clk_enable || cfg_nxt.dac_enable)
			&& (cfg_nxt.sensor_type_select == demag_pkg::TES_POS);
		case (cfg_r.input_select)
			demag_pkg::IS_A: cmp_level = cmp_on_r && phase_q[0];
			demag_pkg::IS_B: cmp_level = cmp_on_r && phase_q[1];
			demag_pkg::IS_C: cmp_level = cmp_on_r && phase_q[2];
			default:         cmp_level = 1'b0;
		endcase
		// speed sensor mode bypasses the comparator path entirely
		speed_nxt = (cfg_r.sensor_type_select != demag_pkg::TES_POS) ? phase_q : 3'h0;
		ext_nxt   = (cfg_nxt.threshold_select == demag_pkg::VR_EXT);
		tick      = (div_r == 16'h0000);
		div_nxt   = tick ? 16'(SAMPLE_BASE * (int'(cfg_r.sampling_window_rate) + 1) - 1)
			: div_r - 16'h0001;
		zc_nxt    = cmp_on_r && (cfg_r.voltage_mode ? evt_in.pwm_sample : tick);
	end

	// sampling flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_on_r <= 1'b0;
			div_r    <= 16'h0000;
			zc_r     <= 1'b0;
			speed_r  <= 3'h0;
			ext_r    <= 1'b0;
		end else begin
			cmp_on_r <= cmp_on_nxt;
			div_r    <= div_nxt;
			zc_r     <= zc_nxt;
			speed_r  <= speed_nxt;
			ext_r    <= ext_nxt;
		end
	end

	// ****************************************
	// demagnetisation event sequencer
	// ****************************************
	// window length in cycles; durations in us scaled by CYC_PER_US
	always_comb begin
		int win_us;
		win_us = 0;
		if (cfg_r.demag_window_len[3]) begin
			win_us = demag_pkg::WIN_LONG_BASE_US
				+ demag_pkg::WIN_LONG_STEP_US * int'(cfg_r.demag_window_len[2:0]);
		end else begin
			win_us = demag_pkg::WIN_SHORT_STEP_US * (int'(cfg_r.demag_window_len) + 1);
		end
		win_cycles = demag_pkg::WIN_W'(win_us * CYC_PER_US);
	end

	// next state: commutation wins while the comparator is on and restarts everything
	always_comb begin
		det_active  = cmp_on_r;
		c_evt       = evt_in.c_hw || swc_r;
		d_level     = cfg_r.zero_vs_demag_polarity ? cfg_r.edge_polarity_bit
			: !cfg_r.edge_polarity_bit;
		d_match     = (cmp_level == d_level);
		state_nxt   = state_r;
		win_nxt     = win_r;
		count_nxt   = count_r;
		d_pulse_nxt = 1'b0;
		if (!det_active) begin
			state_nxt = demag_pkg::ST_WAIT_C;
			count_nxt = 4'h0;
			win_nxt   = '0;
		end else if (c_evt) begin
			count_nxt = 4'h0;
			if (cfg_r.sensor_mode_bit) begin
				state_nxt = demag_pkg::ST_FILTER;
				win_nxt   = '0;
			end else begin
				state_nxt = demag_pkg::ST_BLANK;
				win_nxt   = win_cycles - 1'b1;
			end
		end else begin
			case (state_r)
				demag_pkg::ST_BLANK: begin
					if (evt_in.d_sim) begin
						d_pulse_nxt = 1'b1;
						state_nxt   = demag_pkg::ST_WAIT_Z;
					end else if (win_r == '0) begin
						state_nxt = demag_pkg::ST_FILTER;
					end else begin
						win_nxt = win_r - 1'b1;
					end
				end
				demag_pkg::ST_FILTER: begin
					if (evt_in.d_sim) begin
						d_pulse_nxt = 1'b1;
						state_nxt   = demag_pkg::ST_WAIT_Z;
					end else if (tick && cfg_r.hw_demag_en) begin
						if (!d_match) begin
							count_nxt = 4'h0; // only consecutive hits count
						end else if (cfg_r.sensor_mode_bit
							|| count_r == cfg_r.demag_event_limit) begin
							d_pulse_nxt = 1'b1;
							count_nxt   = 4'h0;
							state_nxt   = demag_pkg::ST_WAIT_Z;
						end else begin
							count_nxt = count_r + 4'h1;
						end
					end
				end
				demag_pkg::ST_WAIT_Z: if (evt_in.z_evt) state_nxt = demag_pkg::ST_WAIT_C;
				default: state_nxt = state_r; // wait for commutation, demag ignored
			endcase
		end
		zen_nxt = (state_nxt == demag_pkg::ST_WAIT_Z);
	end

	// sequencer flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r   <= demag_pkg::ST_WAIT_C;
			win_r     <= '0;
			count_r   <= 4'h0;
			d_pulse_r <= 1'b0;
			zen_r     <= 1'b0;
		end else begin
			state_r   <= state_nxt;
			win_r     <= win_nxt;
			count_r   <= count_nxt;
			d_pulse_r <= d_pulse_nxt;
			zen_r     <= zen_nxt;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign prdata            = prdata_r;
	assign pready            = pready_r;
	assign pslverr           = pslverr_r;
	assign comparator_on     = cmp_on_r;
	assign thr_select        = cfg_r.threshold_select;
	assign ext_threshold_sel = ext_r;
	assign d_event           = d_pulse_r;
	assign z_detect_enable   = zen_r;
	assign zc_sample         = zc_r;
	assign speed_inputs      = speed_r;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	apb_wait_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
		else $error("apb answer not one wait state");
	unmapped_err_a: assert property (psel && penable && !pready && paddr > demag_pkg::ADDR_STATUS
		|=> pslverr && pready)
		else $error("unmapped access not flagged");
	cmp_gate_a: assert property (!cfg_r.clk_enable && !cfg_r.dac_enable
		&& !cfg_nxt.clk_enable && !cfg_nxt.dac_enable |=> !comparator_on)
		else $error("comparator on while disabled");
	blank_start_a: assert property (det_active && c_evt && !cfg_r.sensor_mode_bit
		|=> state_r == demag_pkg::ST_BLANK && win_r == $past(win_cycles) - 1'b1)
		else $error("blanking not started on commutation");
	sensor_skip_a: assert property (det_active && c_evt && cfg_r.sensor_mode_bit
		|=> state_r == demag_pkg::ST_FILTER)
		else $error("sensor mode did not skip window");
	count_clear_a: assert property (det_active && c_evt |=> count_r == 4'h0)
		else $error("counter not cleared by commutation");
	blank_quiet_a: assert property (state_r == demag_pkg::ST_BLANK && !evt_in.d_sim
		|=> !d_event)
		else $error("demag event inside blanking window");
	sim_limit_a: assert property (det_active && !c_evt && evt_in.d_sim
		&& (state_r == demag_pkg::ST_BLANK || state_r == demag_pkg::ST_FILTER)
		|=> d_event ##1 !d_event)
		else $error("simulated demag not passed at once");
	limit_fire_a: assert property (det_active && !c_evt && tick && cfg_r.hw_demag_en
		&& state_r == demag_pkg::ST_FILTER && !evt_in.d_sim && d_match
		&& count_r == cfg_r.demag_event_limit |=> d_event && z_detect_enable)
		else $error("limit reached without demag event");
	flag_set_a: assert property (d_event |-> d_flag_r)
		else $error("demag flag not set with event");

	blank_end_c: cover property (state_r == demag_pkg::ST_BLANK ##1 state_r == demag_pkg::ST_FILTER);
	hw_fire_c: cover property (state_r == demag_pkg::ST_FILTER && count_r != 4'h0 ##1 d_event);
	swc_c: cover property (swc_r && det_active);
	zdone_c: cover property (z_detect_enable ##1 !z_detect_enable);
endmodule
`default_nettype wire

/* File: sim/phase_model.sv */
// behavioural motor winding model driving the three phase comparator levels
`timescale 1ns/10ps
`default_nettype none
module phase_model (
	input  wire logic       pclk,
	input  wire logic [2:0] level_set,
	input  wire logic       encoder_mode,
	output var  logic       phase_input_a,
	output var  logic       phase_input_b,
	output var  logic       phase_input_c
);
	// ****************************************
	// winding levels
	// ****************************************
	// start low so nothing unknown reaches the synchroniser
	initial begin
		phase_input_a = 1'b0;
		phase_input_b = 1'b0;
		phase_input_c = 1'b0;
	end

	// levels move after an edge, like a winding seen through its resistor
	always @(posedge pclk) begin
		phase_input_a <= level_set[0];
		phase_input_b <= level_set[1];
		// encoder uses a and b only, c is left floating and wanders
		phase_input_c <= encoder_mode ? ~phase_input_c : level_set[2];
	end
endmodule
`default_nettype wire

/* File: sim/tb_demag_detector.sv */
// self-checking bench for the demagnetisation event detector
`timescale 1ns/10ps
`default_nettype none
module tb_demag_detector;
	logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, re, enc;
	logic [7:0]         paddr;
	logic [31:0]        pwdata, prdata, rq;
	logic [2:0]         lvl, thr_select, speed_inputs;
	logic               ph_a, ph_b, ph_c, comparator_on, ext_threshold_sel;
	logic               d_event, z_detect_enable, zc_sample;
	demag_pkg::evt_in_t evt;
	int                 n_errors, total_checks, cyc;

	// ****************************************
	// clock, partner and device
	// ****************************************
	always #2.5 pclk = ~pclk;

	phase_model i_phase (.pclk(pclk), .level_set(lvl), .encoder_mode(enc),
		.phase_input_a(ph_a), .phase_input_b(ph_b), .phase_input_c(ph_c));

	// short window and divider units keep the run brief
	demag_detector #(.CYC_PER_US(1), .SAMPLE_BASE(2)) i_dut (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .phase_input_a(ph_a), .phase_input_b(ph_b),
		.phase_input_c(ph_c), .evt_in(evt), .comparator_on(comparator_on),
		.thr_select(thr_select), .ext_threshold_sel(ext_threshold_sel),
		.d_event(d_event), .z_detect_enable(z_detect_enable), .zc_sample(zc_sample),
		.speed_inputs(speed_inputs));

	// ****************************************
	// helpers
	// ****************************************
	task automatic wrap_up;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: %s got %h exp %h", $time, s, got, exp);
		end
	endtask

	// apb cycle: hold everything until pready is sampled high
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge pclk);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
			chk(32'h0, 32'h1, "no pready");
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask

	// one-cycle event pulse; bit 3 commutation, 2 simulated d, 1 zero, 0 pwm
	task automatic pulse(input int b);
		@(posedge pclk);
		evt <= demag_pkg::evt_in_t'(4'(1 << b));
		@(posedge pclk);
		evt <= '0;
	endtask

	// first d_event must land in lo..hi cycles; lo of 0 means none up to hi
	task automatic dwait(input int lo, input int hi, input string s);
		int n;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (d_event !== 1'b1 && n <= hi);
		chk(32'(lo == 0 ? n > hi : (n >= lo && n <= hi)), 32'h1, s);
	endtask

	task automatic zcount(input int nc, output int k);
		k = 0;
		repeat (nc) begin
			@(posedge pclk);
			k += int'(zc_sample === 1'b1);
		end
	endtask

	// hang guard
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			wrap_up();
		end
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		int k, w, lim;
		logic [7:0] tbl [3];
		tbl = '{8'h00, 8'h02, 8'h93};
		pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0;
		pwdata = '0; lvl = 3'b001; evt = '0; enc = 0; n_errors = 0; total_checks = 0;
		cyc = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(8'h10, 1'b0, '0);
		chk(rq, {24'h0, demag_pkg::WIN_RESET, demag_pkg::LIMIT_RESET}, "filter reset");
		apb(8'h24, 1'b0, '0);
		chk(32'(re), 32'h1, "unmapped");
		chk(32'(comparator_on), 32'h0, "comparator reset");
		for (int e = 1; e < 3; e++) begin
			wr(8'h04, e);
			repeat (2) @(posedge pclk);
			chk(32'(comparator_on), 32'h1, "comparator enable");
		end
		wr(8'h04, 32'h0000_0001);
		for (int t = 0; t < 8; t++) begin
			wr(8'h08, t);
			@(posedge pclk);
			chk({thr_select, ext_threshold_sel}, {t[2:0], t == 7}, "threshold");
		end
		for (int p = 0; p < 3; p++) begin
			lvl <= 3'(1 << p);
			for (int s = 0; s < 3; s++) begin
				wr(8'h00, s);
				repeat (6) @(posedge pclk);
				apb(8'h20, 1'b0, '0);
				chk(32'(rq[1]), 32'(s == p), "input select");
			end
		end
		wr(8'h14, 32'h0000_0001);
		lvl <= 3'b101;
		repeat (8) @(posedge pclk);
		chk({comparator_on, speed_inputs}, 4'b0101, "speed mode");
		wr(8'h14, 32'h0000_0000);
		wr(8'h0c, 32'h0000_0001);
		zcount(40, k);
		chk(32'(k >= 9 && k <= 11), 32'h1, "sample rate");
		wr(8'h18, 32'h0000_000c);
		zcount(20, k);
		pulse(0);
		zcount(3, w);
		chk(32'(k), 32'h0, "voltage idle");
		chk(32'(w), 32'h1, "voltage pacing");
		wr(8'h18, 32'h0000_0008);
		wr(8'h0c, 32'h0000_0000);
		wr(8'h00, 32'h0000_0000);
		lvl <= 3'b001;
		for (int t = 0; t < 3; t++) begin
			wr(8'h10, tbl[t]);
			w = tbl[t][7:4] < 8 ? 5 * (tbl[t][7:4] + 1) : 60 + 20 * (tbl[t][7:4] - 8);
			lim = tbl[t][3:0] + 1;
			pulse(3);
			dwait(w + 1 + (lim - 1) * 2, w + 6 + lim * 2, "window and filter");
			chk(32'(z_detect_enable), 32'h1, "z enable");
			pulse(1);
			repeat (2) @(posedge pclk);
			chk(32'(z_detect_enable), 32'h0, "z clear");
		end
		pulse(3);
		repeat (30) @(posedge pclk);
		pulse(3);
		dwait(w + 1 + (lim - 1) * 2, w + 6 + lim * 2, "restart");
		wr(8'h10, 32'h0000_0090);
		wr(8'h1c, 32'h0000_0001);
		dwait(81, 89, "software commutation");
		wr(8'h10, 32'h0000_0000);
		lvl <= 3'b000;
		repeat (6) @(posedge pclk);
		pulse(3);
		dwait(0, 40, "wrong level");
		wr(8'h18, 32'h0000_0009);
		pulse(3);
		dwait(6, 13, "inverted level");
		wr(8'h18, 32'h0000_0008);
		lvl <= 3'b001;
		wr(8'h10, 32'h0000_00ff);
		pulse(3);
		repeat (3) @(posedge pclk);
		pulse(2);
		dwait(1, 2, "simulated d");
		wr(8'h04, 32'h0000_0005);
		pulse(3);
		dwait(1, 8, "sensor mode");
		pulse(2);
		dwait(0, 20, "d after d");
		apb(8'h20, 1'b0, '0);
		chk(32'(rq[0]), 32'h1, "demag flag");
		chk(32'(rq[3:2]), 32'h3, "wait z state");
		wr(8'h20, 32'h0000_0001);
		apb(8'h20, 1'b0, '0);
		chk(32'(rq[0]), 32'h0, "flag clear");
		wrap_up();
	end
endmodule
`default_nettype wire
